// ===== core/ewd_core.sv
// Enhanced watchdog: registers, unlock sequence, mode decode and outputs
`timescale 1ns/1ps
`default_nettype none
module ewd_core #(
  parameter logic [ewd_pkg::CNT_W-1:0] P_BASE_OSC_CYCLES = ewd_pkg::BASE_OSC_CYCLES
) (
  input  wire logic                       i_core_clk,
  input  wire logic                       i_rstn,
  input  wire logic                       i_osc,
  input  wire logic                       i_always_on_fuse,
  input  wire logic                       i_restart,
  input  wire logic                       i_vector_ack,
  input  wire ewd_pkg::ewd_bus_t          i_bus,
  output logic [ewd_pkg::DATA_W-1:0]      o_rdata,
  output logic                            o_sys_reset,
  output logic                            o_timeout_irq,
  output logic                            o_irq
);

  // Reset release: asynchronous assert, two-stage synchronous release
  logic [1:0] rst_pipe;
  logic       rst_n;

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'h1};
    end
  end

  assign rst_n = rst_pipe[1];

  // Whole block state; declared first since the counter reads the select
  ewd_pkg::ewd_core_st_t st;
  ewd_pkg::ewd_core_st_t next_st;

  // Oscillator ticks and the time-out counter
  logic                      tick;
  logic                      expire;
  logic [ewd_pkg::CNT_W-1:0] count;
  logic                      run;

  ewd_osc_sync u_osc_sync (
    .i_core_clk (i_core_clk),
    .i_rst_n    (rst_n),
    .i_osc      (i_osc),
    .o_tick     (tick)
  );

  ewd_tmo_counter #(
    .P_BASE_OSC_CYCLES (P_BASE_OSC_CYCLES)
  ) u_tmo_counter (
    .i_core_clk (i_core_clk),
    .i_rst_n    (rst_n),
    .i_tick     (tick),
    .i_run      (run),
    .i_restart  (i_restart),
    .i_sel      (st.ps),
    .o_count    (count),
    .o_expire   (expire)
  );

  // Bus decode
  logic wr_ctrl;
  logic wr_cause;
  logic wr_clr;
  logic wr_en;
  logic unlock_wr;
  logic do_reset;
  logic do_irq;
  logic [3:0] wr_ps;

  assign wr_ctrl   = i_bus.we && ewd_pkg::reg_hit(i_bus.addr, ewd_pkg::OFS_CTRL);
  assign wr_cause  = i_bus.we && ewd_pkg::reg_hit(i_bus.addr, ewd_pkg::OFS_CAUSE);
  assign wr_clr    = i_bus.we && ewd_pkg::reg_hit(i_bus.addr, ewd_pkg::OFS_EVT_CLR);
  assign wr_en     = i_bus.we && ewd_pkg::reg_hit(i_bus.addr, ewd_pkg::OFS_EVT_EN);
  assign unlock_wr = wr_ctrl && i_bus.wdata[ewd_pkg::BIT_CHG_EN] && i_bus.wdata[ewd_pkg::BIT_RST_EN];
  assign wr_ps     = {i_bus.wdata[ewd_pkg::BIT_PS_HI], i_bus.wdata[ewd_pkg::PS_LO_MSB:ewd_pkg::BIT_PS_LO]};

  // Mode decode at expiry: combined mode resets only if the first interrupt went unserved
  assign do_reset = expire && st.rst_en && (!st.irq_en || st.irq_flag);
  assign do_irq   = expire && st.irq_en && !do_reset;
  assign run      = st.rst_en || st.irq_en;

  always_comb begin
    next_st           = st;
    next_st.sys_reset = 1'h0;
    next_st.rdata     = ewd_pkg::RST_DATA;

    // Unlock window closes by itself after four cycles
    if (st.unlk == ewd_pkg::UNLK_OPEN) begin
      if (st.win_cnt == ewd_pkg::WIN_LAST) begin
        next_st.unlk = ewd_pkg::UNLK_IDLE;
      end else begin
        next_st.win_cnt = st.win_cnt + ewd_pkg::WIN_ONE;
      end
    end

    // Control/status write; interrupt enable, flag clear and setting reset enable are free, the rest is guarded
    if (wr_ctrl) begin
      next_st.irq_en = i_bus.wdata[ewd_pkg::BIT_IRQ_EN];
      if (i_bus.wdata[ewd_pkg::BIT_IRQ_FLAG]) begin
        next_st.irq_flag = 1'h0;
      end
      if (st.unlk == ewd_pkg::UNLK_OPEN && !i_bus.wdata[ewd_pkg::BIT_CHG_EN]) begin
        next_st.rst_en = i_bus.wdata[ewd_pkg::BIT_RST_EN];
        next_st.ps     = wr_ps;
        next_st.unlk   = ewd_pkg::UNLK_IDLE;
      end else if (unlock_wr) begin
        next_st.rst_en  = 1'h1;
        next_st.unlk    = ewd_pkg::UNLK_OPEN;
        next_st.win_cnt = ewd_pkg::WIN_ZERO;
      end else begin
        next_st.rst_en = st.rst_en | i_bus.wdata[ewd_pkg::BIT_RST_EN];
      end
    end

    // Vector execution clears the flag, and in combined mode drops to reset mode
    if (i_vector_ack) begin
      next_st.irq_flag = 1'h0;
      if (st.irq_en && st.rst_en) begin
        next_st.irq_en = 1'h0;
      end
    end

    // Reset cause: only a zero write clears, the watchdog sets
    if (wr_cause && !i_bus.wdata[ewd_pkg::BIT_RST_FLAG]) begin
      next_st.rst_flag = 1'h0;
    end

    // Event status clear and enable
    if (wr_clr) begin
      next_st.evt_stat = st.evt_stat & ~i_bus.wdata[ewd_pkg::EVT_W-1:0];
    end
    if (wr_en) begin
      next_st.evt_en = i_bus.wdata[ewd_pkg::EVT_W-1:0];
    end

    // Hardware sets come last so a set wins over a clear in the same cycle
    if (do_irq) begin
      next_st.irq_flag                  = 1'h1;
      next_st.evt_stat[ewd_pkg::EVT_IRQ] = 1'h1;
    end
    if (do_reset) begin
      next_st.sys_reset                  = 1'h1;
      next_st.rst_flag                   = 1'h1;
      next_st.irq_flag                   = 1'h0;
      next_st.irq_en                     = 1'h0;
      next_st.evt_stat[ewd_pkg::EVT_RST] = 1'h1;
    end

    // Overrides: the flag holds reset enabled, the fuse locks reset mode
    if (next_st.rst_flag) begin
      next_st.rst_en = 1'h1;
    end
    if (i_always_on_fuse) begin
      next_st.rst_en = 1'h1;
      next_st.irq_en = 1'h0;
    end

    // Read data stand in the cycle after the strobe only
    if (i_bus.re) begin
      unique case (i_bus.addr)
        ewd_pkg::OFS_CTRL: begin
          next_st.rdata[ewd_pkg::BIT_IRQ_FLAG] = st.irq_flag;
          next_st.rdata[ewd_pkg::BIT_IRQ_EN]   = st.irq_en;
          next_st.rdata[ewd_pkg::BIT_PS_HI]    = st.ps[3];
          next_st.rdata[ewd_pkg::BIT_CHG_EN]   = st.unlk == ewd_pkg::UNLK_OPEN;
          next_st.rdata[ewd_pkg::BIT_RST_EN]   = st.rst_en;
          next_st.rdata[ewd_pkg::PS_LO_MSB:ewd_pkg::BIT_PS_LO] = st.ps[2:0];
        end
        ewd_pkg::OFS_CAUSE: begin
          next_st.rdata[ewd_pkg::BIT_RST_FLAG] = st.rst_flag;
        end
        ewd_pkg::OFS_EVT_STAT: begin
          next_st.rdata[ewd_pkg::EVT_W-1:0] = st.evt_stat;
        end
        ewd_pkg::OFS_EVT_EN: begin
          next_st.rdata[ewd_pkg::EVT_W-1:0] = st.evt_en;
        end
        default: begin
          next_st.rdata = ewd_pkg::RST_DATA; // Unmapped and write-only read as zero
        end
      endcase
    end

    // Registered outputs
    next_st.irq     = |(next_st.evt_stat & next_st.evt_en);
    next_st.tmo_irq = next_st.irq_flag && next_st.irq_en;
  end

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st          <= '0;
      st.unlk     <= ewd_pkg::UNLK_IDLE;
      st.ps       <= ewd_pkg::RST_PS;
      st.evt_stat <= ewd_pkg::RST_EVT;
      st.evt_en   <= ewd_pkg::RST_EVT;
    end else begin
      st <= next_st;
    end
  end

  assign o_rdata       = st.rdata;
  assign o_sys_reset   = st.sys_reset;
  assign o_timeout_irq = st.tmo_irq;
  assign o_irq         = st.irq;

  // Checks
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_unlock;
    unlock_wr && st.unlk == ewd_pkg::UNLK_IDLE;
  endsequence

  sequence s_quiet_window;
    !i_bus.we [*4];
  endsequence

  // First expiry of combined mode, before any interrupt is pending
  sequence s_first_expiry;
    expire && st.irq_en && st.rst_en && !st.irq_flag;
  endsequence

  // A control write inside the window can close or restart it, so only quiet windows are timed
  a_window_opens: assert property (s_unlock ##1 (!wr_ctrl) [*3] |=> st.unlk == ewd_pkg::UNLK_OPEN)
    else $error("unlock window shorter than four cycles");

  a_window_closes: assert property (s_unlock ##1 s_quiet_window |=> st.unlk == ewd_pkg::UNLK_IDLE)
    else $error("change enable did not self-clear");

  a_locked_ps: assert property (st.unlk == ewd_pkg::UNLK_IDLE |=> $stable(st.ps))
    else $error("prescaler changed while locked");

  a_locked_rst_en: assert property (st.unlk == ewd_pkg::UNLK_IDLE && st.rst_en |=> st.rst_en)
    else $error("reset enable cleared while locked");

  a_fuse_lock: assert property (i_always_on_fuse |=> st.rst_en && !st.irq_en)
    else $error("fuse did not lock reset mode");

  a_flag_forces: assert property (st.rst_flag |-> st.rst_en)
    else $error("reset enable low while reset flag set");

  a_reset_pulse: assert property (do_reset |=> o_sys_reset ##1 !o_sys_reset)
    else $error("system reset not a one-cycle pulse");

  a_irq_mode: assert property (do_irq |=> st.irq_flag && !o_sys_reset ##1 o_timeout_irq || !st.irq_en)
    else $error("interrupt mode expiry did not raise the flag");

  a_combined_first: assert property (s_first_expiry |=> !o_sys_reset)
    else $error("combined mode reset on first expiry");

  a_combined_flag: assert property (s_first_expiry |=> st.irq_flag && st.rst_en)
    else $error("combined mode first expiry did not raise the flag");

  a_vector_clear: assert property (i_vector_ack && !expire && st.rst_en |=> !st.irq_flag && !st.irq_en)
    else $error("vector did not clear flag and enable");

  // Software clears stick unless a new expiry lands in the same cycle
  a_flag_w1c: assert property (wr_ctrl && i_bus.wdata[ewd_pkg::BIT_IRQ_FLAG] && !do_irq |=> !st.irq_flag)
    else $error("flag write of one did not clear");

  a_cause_clr: assert property (wr_cause && !i_bus.wdata[ewd_pkg::BIT_RST_FLAG] && !do_reset |=> !st.rst_flag)
    else $error("reset flag zero write did not clear");

  // Expiry side effects and the stopped mode
  a_reset_keeps: assert property (do_reset |=> st.rst_flag && st.rst_en)
    else $error("watchdog not kept on after its reset");

  a_irq_status: assert property (do_irq |=> st.evt_stat[ewd_pkg::EVT_IRQ])
    else $error("interrupt expiry not noted in event status");

  a_reset_status: assert property (do_reset |=> st.evt_stat[ewd_pkg::EVT_RST])
    else $error("reset expiry not noted in event status");

  a_stopped_quiet: assert property (!run |=> !expire && !o_sys_reset)
    else $error("stopped watchdog expired");

  a_fuse_no_irq: assert property (i_always_on_fuse |=> !o_timeout_irq)
    else $error("fuse did not mask the time-out interrupt");

endmodule
`default_nettype wire

// ===== core/ewd_osc_sync.sv
// Oscillator sampler: turns the slow watchdog oscillator into core-clock ticks
`timescale 1ns/1ps
`default_nettype none
module ewd_osc_sync (
  input  wire logic i_core_clk,
  input  wire logic i_rst_n,
  input  wire logic i_osc,
  output logic      o_tick
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic tick;
  } ewd_sync_st_t;

  ewd_sync_st_t st;
  ewd_sync_st_t next_st;

  // Two stages before any logic looks at the level; edge found on stages two and three
  always_comb begin
    next_st      = st;
    next_st.s1   = i_osc;
    next_st.s2   = st.s1;
    next_st.s3   = st.s2;
    next_st.tick = st.s2 & ~st.s3;
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_tick = st.tick;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  // A tick is a single cycle, so a stuck level never counts twice
  a_tick_single: assert property (o_tick |=> !o_tick)
    else $error("oscillator tick longer than one cycle");

endmodule
`default_nettype wire

// ===== core/ewd_pkg.sv
// Shared constants, types and decode functions of the enhanced watchdog
package ewd_pkg;

  // Clock rates: core clock and the watchdog's own oscillator
  localparam int unsigned CORE_CLK_HZ = 100_000_000;
  localparam int unsigned OSC_HZ      = 128_000;

  // Register bus shape
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL     = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CAUSE    = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_EVT_STAT = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_EVT_CLR  = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_EVT_EN   = 8'h10;

  // Control/status register field positions
  localparam int unsigned BIT_IRQ_FLAG = 7;
  localparam int unsigned BIT_IRQ_EN   = 6;
  localparam int unsigned BIT_PS_HI    = 5;
  localparam int unsigned BIT_CHG_EN   = 4;
  localparam int unsigned BIT_RST_EN   = 3;
  localparam int unsigned PS_LO_MSB    = 2;
  localparam int unsigned BIT_PS_LO    = 0;

  // Reset cause register field position
  localparam int unsigned BIT_RST_FLAG = 3;

  // Event status/clear/enable layout
  localparam int unsigned EVT_W   = 2;
  localparam int unsigned EVT_IRQ = 0;
  localparam int unsigned EVT_RST = 1;

  // Reset values
  localparam logic [DATA_W-1:0] RST_DATA = 8'h00;
  localparam logic [3:0]        RST_PS   = 4'h0;
  localparam logic [EVT_W-1:0]  RST_EVT  = 2'h0;

  // Unlock window length in core clock cycles
  localparam logic [2:0] UNLOCK_CYCLES = 3'h4;
  localparam logic [2:0] WIN_LAST      = 3'h3;
  localparam logic [2:0] WIN_ZERO      = 3'h0;
  localparam logic [2:0] WIN_ONE       = 3'h1;

  // Time-out counter: base period and the widest legal select code
  localparam int unsigned CNT_W        = 21;
  localparam logic [CNT_W-1:0] CNT_ZERO = 21'h0;
  localparam logic [CNT_W-1:0] CNT_ONE  = 21'h1;
  localparam logic [CNT_W-1:0] BASE_OSC_CYCLES = 21'h800;
  localparam logic [3:0] PS_MAX = 4'h9;

  // Register bus request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              we;
    logic              re;
  } ewd_bus_t;

  // Timed unlock sequence states
  typedef enum logic [1:0] {
    UNLK_IDLE = 2'b01,
    UNLK_OPEN = 2'b10
  } ewd_unlk_t;

  // Whole state of the core module
  typedef struct packed {
    ewd_unlk_t         unlk;
    logic [2:0]        win_cnt;
    logic              irq_en;
    logic              irq_flag;
    logic              rst_en;
    logic [3:0]        ps;
    logic              rst_flag;
    logic [EVT_W-1:0]  evt_stat;
    logic [EVT_W-1:0]  evt_en;
    logic [DATA_W-1:0] rdata;
    logic              sys_reset;
    logic              irq;
    logic              tmo_irq;
  } ewd_core_st_t;

  // Oscillator cycles for a select code; reserved codes act as the longest
  function automatic logic [CNT_W-1:0] timeout_cycles(input logic [3:0] sel, input logic [CNT_W-1:0] base);
    if (sel > PS_MAX) begin
      return base << PS_MAX;
    end
    return base << sel;
  endfunction

  // Address match of one register
  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] ofs);
    return addr == ofs;
  endfunction

endpackage

// ===== core/ewd_tmo_counter.sv
// Time-out counter: counts oscillator ticks against the selected period
`timescale 1ns/1ps
`default_nettype none
module ewd_tmo_counter #(
  parameter logic [ewd_pkg::CNT_W-1:0] P_BASE_OSC_CYCLES = ewd_pkg::BASE_OSC_CYCLES
) (
  input  wire logic                      i_core_clk,
  input  wire logic                      i_rst_n,
  input  wire logic                      i_tick,
  input  wire logic                      i_run,
  input  wire logic                      i_restart,
  input  wire logic [3:0]                i_sel,
  output logic [ewd_pkg::CNT_W-1:0]      o_count,
  output logic                           o_expire
);

  typedef struct packed {
    logic [ewd_pkg::CNT_W-1:0] cnt;
    logic                      expire;
  } ewd_cnt_st_t;

  ewd_cnt_st_t st;
  ewd_cnt_st_t next_st;
  logic [ewd_pkg::CNT_W-1:0] limit;

  assign limit = ewd_pkg::timeout_cycles(i_sel, P_BASE_OSC_CYCLES);

  // Compare with >= so a shorter period chosen mid-count expires on the next tick
  always_comb begin
    next_st        = st;
    next_st.expire = 1'h0;
    if (i_restart || !i_run) begin
      next_st.cnt = ewd_pkg::CNT_ZERO;
    end else if (i_tick) begin
      if (st.cnt + ewd_pkg::CNT_ONE >= limit) begin
        next_st.cnt    = ewd_pkg::CNT_ZERO;
        next_st.expire = 1'h1;
      end else begin
        next_st.cnt = st.cnt + ewd_pkg::CNT_ONE;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_count  = st.cnt;
  assign o_expire = st.expire;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  a_restart_zero: assert property (i_restart |=> o_count == ewd_pkg::CNT_ZERO)
    else $error("restart did not clear the counter");

  a_count_ticks: assert property (i_run && !i_restart && !i_tick |=> $stable(o_count) || !$past(i_run))
    else $error("counter moved without an oscillator tick");

endmodule
`default_nettype wire

// ===== test/ewd_partner.sv
// Far-side model: watchdog oscillator, CPU vector execution and system reset logic
`timescale 1ns/1ps
`default_nettype none
module ewd_partner #(
  parameter real P_OSC_HALF = 3906.25
) (
  input  wire logic i_core_clk,
  input  wire logic i_ack_en,
  input  wire logic i_timeout_irq,
  input  wire logic i_sys_reset,
  output logic      o_osc,
  output logic      o_vector_ack,
  output var int    o_reset_count
);
  logic [2:0] hold;

  // Free-running oscillator, phase unrelated to the core clock
  initial begin
    o_vector_ack = 1'b0;
    hold = 3'h0;
    o_reset_count = 0;
    o_osc = 1'b0;
    #3.3;
    forever #(P_OSC_HALF) o_osc = ~o_osc;
  end

  // CPU runs the vector once; hold-off lets the flag clear before the next
  always @(posedge i_core_clk) begin
    o_vector_ack <= i_ack_en && i_timeout_irq === 1'b1 && hold == 3'h0 && !o_vector_ack;
    hold <= o_vector_ack ? 3'h7 : (hold != 3'h0 ? hold - 3'h1 : 3'h0);
  end

  // Reset logic only counts requests; it never resets the watchdog itself
  always @(posedge i_core_clk) begin
    if (i_sys_reset === 1'b1) o_reset_count <= o_reset_count + 1;
  end
endmodule
`default_nettype wire

// ===== test/testbench.sv
// Self-checking bench of the enhanced watchdog core
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fail_count++; $display("CHECK FAILED %0t got %h exp %h", $time, a, b); end end
module testbench;
  localparam logic [20:0] BASE = 21'h4;
  localparam logic [7:0]  C    = ewd_pkg::OFS_CTRL;
  localparam logic [7:0]  RC   = ewd_pkg::OFS_CAUSE;
  localparam logic [7:0]  ST   = ewd_pkg::OFS_EVT_STAT;
  localparam logic [7:0]  CL   = ewd_pkg::OFS_EVT_CLR;
  localparam logic [7:0]  EN   = ewd_pkg::OFS_EVT_EN;
  logic              clk = 1'b0;
  logic              rstn, fuse, restart, ack_en, osc, vack, sys_rst, tirq, irq, re_q;
  logic [7:0]        rdata, exp_v;
  logic [3:0]        s;
  ewd_pkg::ewd_bus_t bus;
  logic [7:0]        exp_q[$];
  int                fail_count, compares, n, lo, rst_cnt;

  // 100 MHz core clock
  always #5 clk = ~clk;

  ewd_core #(.P_BASE_OSC_CYCLES(BASE)) dut_u (
    .i_core_clk(clk), .i_rstn(rstn), .i_osc(osc), .i_always_on_fuse(fuse),
    .i_restart(restart), .i_vector_ack(vack), .i_bus(bus), .o_rdata(rdata),
    .o_sys_reset(sys_rst), .o_timeout_irq(tirq), .o_irq(irq));

  // Fast oscillator so the longest select fits the run
  ewd_partner #(.P_OSC_HALF(50.0)) prt_u (
    .i_core_clk(clk), .i_ack_en(ack_en), .i_timeout_irq(tirq),
    .i_sys_reset(sys_rst), .o_osc(osc), .o_vector_ack(vack), .o_reset_count(rst_cnt));

  // Read data stands only in the cycle after the strobe
  always @(posedge clk) begin
    if (re_q === 1'b1) begin
      exp_v = exp_q.pop_front();
      `CHK(rdata, exp_v)
    end
    re_q <= bus.re;
  end

  task automatic conclude();
    if (fail_count == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // One bus cycle, strobe dropped at the next edge
  task automatic acc(input logic [7:0] a, input logic [7:0] d, input logic [1:0] k);
    @(posedge clk);
    bus <= {a, d, k};
    @(posedge clk);
    bus <= '0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    acc(a, d, 2'h2);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    acc(a, 8'h00, 2'h1);
  endtask

  task automatic kick();
    @(posedge clk);
    restart <= 1'b1;
    @(posedge clk);
    restart <= 1'b0;
  endtask

  // Bounded wait for interrupt (0) or reset request (1); n holds cycles waited
  task automatic wait_ev(input bit w, input int lim);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while ((w ? sys_rst : tirq) !== 1'b1 && n < lim);
    if (n >= lim) begin
      fail_count++;
      $display("CHECK FAILED %0t event never came", $time);
      conclude();
    end
  endtask

  initial begin
    rstn = 1'b0;
    fuse = 1'b0;
    restart = 1'b0;
    ack_en = 1'b0;
    bus = '0;
    re_q = 1'b0;
    fail_count = 0;
    compares = 0;
    void'($urandom(32'hAD60));
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    repeat (5) @(posedge clk);
    // Reset values; unmapped and write-only places read zero
    for (int a = 0; a < 24; a += 4) rd(a[7:0], 8'h00);
    // Interrupt mode with event interrupt raised, masked and cleared
    wr(EN, 8'h01);
    wr(C, 8'h40);
    wait_ev(0, 200);
    repeat (3) @(posedge clk);
    #1 `CHK(irq, 1'b1)
    kick();
    rd(C, 8'hC0);
    rd(ST, 8'h01);
    wr(C, 8'hC0);
    rd(C, 8'h40);
    wr(C, 8'h00);
    wr(EN, 8'h00);
    repeat (3) @(posedge clk);
    #1 `CHK(irq, 1'b0)
    wr(CL, 8'h01);
    rd(ST, 8'h00);
    // Restarts at random gaps keep the time-out away
    wr(C, 8'h40);
    repeat (12) begin
      kick();
      #1 `CHK(tirq, 1'b0)
      repeat ($urandom_range(20, 4)) @(posedge clk);
    end
    wr(C, 8'h00);
    // Reset mode: one-cycle request, flag keeps the watchdog on
    wr(C, 8'h08);
    wait_ev(1, 200);
    @(posedge clk);
    #1 `CHK(sys_rst, 1'b0)
    kick();
    rd(RC, 8'h08);
    rd(ST, 8'h02);
    wr(C, 8'h18);
    wr(C, 8'h00);
    rd(C, 8'h08);
    kick();
    wr(RC, 8'h00);
    wr(C, 8'h18);
    wr(C, 8'h00);
    rd(C, 8'h00);
    `CHK(rst_cnt, 1)
    // Locked fields refuse plain writes; window lapses after four cycles
    wr(C, 8'h08);
    kick();
    wr(C, 8'h01);
    rd(C, 8'h08);
    wr(C, 8'h18);
    rd(C, 8'h18);
    repeat (4) @(posedge clk);
    wr(C, 8'h00);
    rd(C, 8'h08);
    // Every select code and one reserved code, timed in core clock cycles
    for (int c = 0; c < 11; c++) begin
      s = (c == 10) ? 4'hC : c[3:0];
      kick();
      wr(C, 8'h18);
      wr(C, {2'h1, s[3], 2'h0, s[2:0]});
      kick();
      wait_ev(0, 25000);
      lo = ((4 << (c > 9 ? 9 : c)) - 1) * 10;
      `CHK(n >= lo && n <= lo + 20, 1'b1)
      rd(C, {2'h3, s[3], 2'h0, s[2:0]});
      wr(C, 8'h80);
    end
    // Combined mode: vector clears enable, next expiry resets
    ack_en <= 1'b1;
    kick();
    wr(C, 8'h18);
    wr(C, 8'h48);
    wait_ev(0, 200);
    repeat (8) @(posedge clk);
    rd(C, 8'h08);
    wait_ev(1, 200);
    @(posedge clk);
    #1 `CHK(rst_cnt, 2)
    // Fuse forces reset mode whatever is written
    @(posedge clk);
    ack_en <= 1'b0;
    fuse <= 1'b1;
    wr(C, 8'h40);
    rd(C, 8'h08);
    repeat (4) @(posedge clk);
    conclude();
  end
endmodule
`default_nettype wire
